// ---- shared/pidfan_pkg.sv ----
package pidfan_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_INT_CLR   = 8'h08;
    localparam logic [7:0] REG_INT_EN    = 8'h0C;
    localparam logic [7:0] REG_GAIN_P    = 8'h10;
    localparam logic [7:0] REG_GAIN_I    = 8'h14;
    localparam logic [7:0] REG_GAIN_D    = 8'h18;
    localparam logic [7:0] REG_LIMITS    = 8'h1C;
    localparam logic [7:0] REG_COOL_THR  = 8'h20;
    localparam logic [7:0] REG_FAN_OVR   = 8'h24;
    localparam logic [7:0] REG_FAN_STAT  = 8'h28;
    localparam logic [7:0] REG_OT_STAT   = 8'h2C;
    localparam logic [7:0] REG_SETPT0    = 8'h30;
    localparam logic [7:0] REG_DRIVE0    = 8'h40;

    // Control register fields.
    localparam int CTRL_OUT_EN_BIT = 0;
    localparam int CTRL_DISP_BIT   = 1;
    localparam int CTRL_OFF_LSB    = 4;

    // Status bit positions (events).
    localparam int ST_TICK_BIT = 0;
    localparam int ST_OT_BIT   = 1;

    // Temperatures are signed 16-bit, 1/16 degree C per LSB.
    localparam logic signed [15:0] HEATER_TRIP_TEMP = 16'sh03C0;
    localparam logic signed [15:0] COOL_THR_RESET   = 16'sh0230;
    localparam logic [31:0]        LIMITS_RESET     = 32'h7FFF_0000;
    localparam logic [15:0]        GAIN_RESET       = 16'h0000;

    // Conversion period and derived cycle count at 125 MHz.
    localparam int CONV_PERIOD_MS = 100;
    localparam int CLK_KHZ        = 125000;
    localparam int CONV_CYCLES    = CONV_PERIOD_MS * CLK_KHZ;

    // Power-supply fan duty: on for PSU_ON ticks out of PSU_PERIOD ticks.
    localparam int PSU_PERIOD_TICKS = 100;
    localparam int PSU_ON_TICKS     = 20;

    // One card report sampled at conversion.
    typedef struct packed {
        logic               is_heater;
        logic signed [15:0] card_temp;
        logic        [15:0] load_current;
        logic        [15:0] load_voltage;
    } pidfan_card_t;

    // Gain set of the loop.
    typedef struct packed {
        logic signed [15:0] kp;
        logic signed [15:0] ki;
        logic signed [15:0] kd;
    } pidfan_gain_t;

endpackage : pidfan_pkg

// ---- hdl/pidfan_top.sv ----
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps

module pidfan_top #(
    parameter int NCARD       = 4,
    parameter int CONV_CYCLES = pidfan_pkg::CONV_CYCLES
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire pidfan_pkg::pidfan_card_t [3:0] card_in,
    input  wire logic                          standby,
    output logic [7:0]                         fan_speed,
    output logic                               psu_fan_on,
    output logic [3:0]                         heater_enable,
    output logic [63:0]                        heater_drive,
    output logic                               conv_tick,
    output logic                               card_temp_display,
    output logic                               irq
);

    ////////////////////////////////////////////////////////////////////////////

    // Fan request of one card, scaled so 0 is off and 255 is full speed.
    function automatic logic [7:0] card_request(input pidfan_pkg::pidfan_card_t c,
                                                input logic signed [15:0] thr);
        logic signed [17:0] rise;
        logic [17:0]        sum;
        rise = 18'sd0;
        sum  = 18'd0;
        if (c.is_heater)
        begin
            rise = 18'(c.card_temp) - 18'sd400;
            sum  = (rise > 0 ? 18'(rise) : 18'd0) + 18'(c.load_current[15:10])
                   + 18'(c.load_voltage[15:10]);
        end
        else if (c.card_temp >= thr)
        begin
            rise = 18'(c.card_temp) - 18'(thr);
            sum  = 18'(rise) + 18'd16;
        end
        // Below threshold the sum stays zero.
        card_request = (sum > 18'd255) ? 8'hFF : sum[7:0];
    endfunction : card_request

    // Sign extension of 16-bit fields for register reads.
    function automatic logic [31:0] sx(input logic signed [15:0] v);
        sx = {{16{v[15]}}, v};
    endfunction : sx

    ////////////////////////////////////////////////////////////////////////////
    // Software state.

    logic [31:0]                 ctrl;
    logic [31:0]                 next_ctrl;
    pidfan_pkg::pidfan_gain_t    gain;
    pidfan_pkg::pidfan_gain_t    next_gain;
    logic [31:0]                 limits;
    logic [31:0]                 next_limits;
    logic signed [15:0]          cool_thr;
    logic signed [15:0]          next_cool_thr;
    logic [8:0]                  fan_ovr;
    logic [8:0]                  next_fan_ovr;
    logic [1:0]                  int_en;
    logic [1:0]                  next_int_en;
    logic [15:0]                 setpt [NCARD];
    logic [15:0]                 next_setpt [NCARD];
    logic                        disp_latched;
    logic                        disp_done;

    // AXI state.
    logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic        bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0]  bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    // Loop and fan state.
    logic [31:0]        tick_cnt, next_tick_cnt;
    logic               tick, next_tick;
    logic [1:0]         status, next_status;
    logic [3:0]         ot_trip, next_ot_trip;
    logic [7:0]         fan, next_fan;
    logic [7:0]         arb;
    logic [6:0]         psu_cnt, next_psu_cnt;
    logic               psu, next_psu;
    logic signed [31:0] integ [NCARD];
    logic signed [31:0] next_integ [NCARD];
    logic signed [15:0] prev_t [NCARD];
    logic signed [15:0] next_prev_t [NCARD];
    logic [15:0]        drive [NCARD];
    logic [15:0]        next_drive [NCARD];
    logic               do_wr;

    assign do_wr = aw_hold && w_hold && !bvalid;

    ////////////////////////////////////////////////////////////////////////////

    // AXI slave and register writes; write address and data are taken in either order.
    always_comb
    begin
        next_aw_hold  = aw_hold;
        next_w_hold   = w_hold;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rresp    = rresp;
        next_rdata    = rdata;
        next_ctrl     = ctrl;
        next_gain     = gain;
        next_limits   = limits;
        next_cool_thr = cool_thr;
        next_fan_ovr  = fan_ovr;
        next_int_en   = int_en;
        for (int i = 0; i < NCARD; i++)
        begin
            next_setpt[i] = setpt[i];
        end
        if (s_axi_awvalid && !aw_hold)
        begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold)
        begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (do_wr)
        begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = 2'b00;
            case (aw_addr)
                pidfan_pkg::REG_CTRL:     next_ctrl     = w_data;
                pidfan_pkg::REG_INT_CLR:  next_bresp    = 2'b00;
                pidfan_pkg::REG_INT_EN:   next_int_en   = w_data[1:0];
                pidfan_pkg::REG_GAIN_P:   next_gain.kp  = w_data[15:0];
                pidfan_pkg::REG_GAIN_I:   next_gain.ki  = w_data[15:0];
                pidfan_pkg::REG_GAIN_D:   next_gain.kd  = w_data[15:0];
                pidfan_pkg::REG_LIMITS:   next_limits   = w_data;
                pidfan_pkg::REG_COOL_THR: next_cool_thr = w_data[15:0];
                pidfan_pkg::REG_FAN_OVR:  next_fan_ovr  = w_data[8:0];
                default:
                begin
                    if (aw_addr[7:4] == pidfan_pkg::REG_SETPT0[7:4] && int'(aw_addr[3:2]) < NCARD)
                    begin
                        next_setpt[aw_addr[3:2]] = w_data[15:0];
                    end
                    else if (aw_addr != pidfan_pkg::REG_STATUS)
                    begin
                        next_bresp = 2'b10;
                    end
                end
            endcase
        end
        if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid)
        begin
            next_rvalid = 1'b1;
            next_rresp  = 2'b00;
            case (s_axi_araddr)
                pidfan_pkg::REG_CTRL:     next_rdata = ctrl;
                pidfan_pkg::REG_STATUS:   next_rdata = {30'h0, status};
                pidfan_pkg::REG_INT_CLR:  next_rdata = 32'h0000_0000;
                pidfan_pkg::REG_INT_EN:   next_rdata = {30'h0, int_en};
                pidfan_pkg::REG_GAIN_P:   next_rdata = sx(gain.kp);
                pidfan_pkg::REG_GAIN_I:   next_rdata = sx(gain.ki);
                pidfan_pkg::REG_GAIN_D:   next_rdata = sx(gain.kd);
                pidfan_pkg::REG_LIMITS:   next_rdata = limits;
                pidfan_pkg::REG_COOL_THR: next_rdata = sx(cool_thr);
                pidfan_pkg::REG_FAN_OVR:  next_rdata = {23'h0, fan_ovr};
                pidfan_pkg::REG_FAN_STAT: next_rdata = {16'h0, arb, fan};
                pidfan_pkg::REG_OT_STAT:  next_rdata = {28'h0, ot_trip};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    if (s_axi_araddr[7:4] == pidfan_pkg::REG_SETPT0[7:4]
                        && int'(s_axi_araddr[3:2]) < NCARD)
                    begin
                        next_rdata = {16'h0, setpt[s_axi_araddr[3:2]]};
                    end
                    else if (s_axi_araddr[7:4] == pidfan_pkg::REG_DRIVE0[7:4]
                             && int'(s_axi_araddr[3:2]) < NCARD)
                    begin
                        next_rdata = {16'h0, drive[s_axi_araddr[3:2]]};
                    end
                    else
                    begin
                        next_rresp = 2'b10;
                    end
                end
            endcase
        end
    end

    // Register the bus and software state.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold  <= 1'b0;
            w_hold   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            bvalid   <= 1'b0;
            bresp    <= 2'b00;
            rvalid   <= 1'b0;
            rresp    <= 2'b00;
            rdata    <= 32'h0000_0000;
            ctrl     <= 32'h0000_0000;
            gain     <= '{pidfan_pkg::GAIN_RESET, pidfan_pkg::GAIN_RESET,
                          pidfan_pkg::GAIN_RESET};
            limits   <= pidfan_pkg::LIMITS_RESET;
            cool_thr <= pidfan_pkg::COOL_THR_RESET;
            fan_ovr  <= 9'h000;
            int_en   <= 2'b00;
            for (int i = 0; i < NCARD; i++)
            begin
                setpt[i] <= 16'h0000;
            end
        end
        else
        begin
            aw_hold  <= next_aw_hold;
            w_hold   <= next_w_hold;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
            ctrl     <= next_ctrl;
            gain     <= next_gain;
            limits   <= next_limits;
            cool_thr <= next_cool_thr;
            fan_ovr  <= next_fan_ovr;
            int_en   <= next_int_en;
            for (int i = 0; i < NCARD; i++)
            begin
                setpt[i] <= next_setpt[i];
            end
        end
    end

    // Display select is captured once after reset release, while ctrl still holds its reset value 0, so writes never reach card_temp_display.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disp_latched <= 1'b0;
            disp_done    <= 1'b0;
        end
        else if (!disp_done)
        begin
            disp_latched <= ctrl[pidfan_pkg::CTRL_DISP_BIT];
            disp_done    <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Highest request of all cards.
    always_comb
    begin
        arb = 8'h00;
        for (int i = 0; i < NCARD; i++)
        begin
            if (card_request(card_in[i], cool_thr) > arb)
            begin
                arb = card_request(card_in[i], cool_thr);
            end
        end
    end

    // Conversion timer, PID loops, trips, fans and status.
    always_comb
    begin
        logic signed [31:0] err;
        logic signed [31:0] sum;
        logic               off_req;
        err           = 32'sd0;
        sum           = 32'sd0;
        off_req       = 1'b0;
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 32'd1;
        next_ot_trip  = ot_trip;
        next_fan      = fan;
        next_psu_cnt  = psu_cnt;
        next_psu      = psu;
        next_status   = status;
        if (tick_cnt >= 32'(CONV_CYCLES - 1))
        begin
            next_tick_cnt = 32'd0;
            next_tick     = 1'b1;
        end
        for (int i = 0; i < NCARD; i++)
        begin
            next_integ[i]  = integ[i];
            next_prev_t[i] = prev_t[i];
            next_drive[i]  = drive[i];
            off_req = !ctrl[pidfan_pkg::CTRL_OUT_EN_BIT]
                      || ctrl[pidfan_pkg::CTRL_OFF_LSB + i];
            if (off_req)
            begin
                next_ot_trip[i] = 1'b0;
            end
            if (tick)
            begin
                if (card_in[i].is_heater
                    && card_in[i].card_temp > pidfan_pkg::HEATER_TRIP_TEMP)
                begin
                    next_ot_trip[i] = 1'b1;
                    next_status[pidfan_pkg::ST_OT_BIT] = 1'b1;
                end
                err = 32'(signed'(setpt[i])) - 32'(card_in[i].card_temp);
                next_integ[i] = integ[i] + 32'(gain.ki * err);
                next_prev_t[i] = card_in[i].card_temp;
                sum = 32'(gain.kp * err) + next_integ[i]
                      + 32'(gain.kd * (32'(prev_t[i]) - 32'(card_in[i].card_temp)));
                if (sum > 32'(signed'(limits[31:16])))
                begin
                    next_drive[i] = limits[31:16];
                end
                else if (sum < 32'(signed'(limits[15:0])))
                begin
                    next_drive[i] = limits[15:0];
                end
                else
                begin
                    next_drive[i] = sum[15:0];
                end
            end
        end
        if (tick)
        begin
            next_status[pidfan_pkg::ST_TICK_BIT] = 1'b1;
            next_fan = fan_ovr[8] ? fan_ovr[7:0] : arb;
            next_psu_cnt = (psu_cnt >= 7'(pidfan_pkg::PSU_PERIOD_TICKS - 1))
                           ? 7'd0 : psu_cnt + 7'd1;
            next_psu = psu_cnt < 7'(pidfan_pkg::PSU_ON_TICKS);
        end
        // Clear acts only on bits not being set this cycle.
        if (do_wr && aw_addr == pidfan_pkg::REG_INT_CLR)
        begin
            next_status = next_status & ~(w_data[1:0] & ~(next_status & ~status));
        end
    end

    // Register loop state.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 32'd0;
            tick     <= 1'b0;
            ot_trip  <= 4'h0;
            fan      <= 8'h00;
            psu_cnt  <= 7'd0;
            psu      <= 1'b0;
            status   <= 2'b00;
            for (int i = 0; i < NCARD; i++)
            begin
                integ[i]  <= 32'sd0;
                prev_t[i] <= 16'sd0;
                drive[i]  <= 16'h0000;
            end
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
            ot_trip  <= next_ot_trip;
            fan      <= next_fan;
            psu_cnt  <= next_psu_cnt;
            psu      <= next_psu;
            status   <= next_status;
            for (int i = 0; i < NCARD; i++)
            begin
                integ[i]  <= next_integ[i];
                prev_t[i] <= next_prev_t[i];
                drive[i]  <= next_drive[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Output stage, all registered; standby does not stop the supply fan.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            heater_enable     <= 4'h0;
            heater_drive      <= 64'h0;
            irq               <= 1'b0;
            fan_speed         <= 8'h00;
            psu_fan_on        <= 1'b0;
            conv_tick         <= 1'b0;
            card_temp_display <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NCARD; i++)
            begin
                heater_enable[i] <= !ot_trip[i] && ctrl[pidfan_pkg::CTRL_OUT_EN_BIT]
                                    && !ctrl[pidfan_pkg::CTRL_OFF_LSB + i] && !standby;
                heater_drive[16*i +: 16] <= ot_trip[i] ? 16'h0000 : drive[i];
            end
            irq               <= |(status & int_en);
            fan_speed         <= fan;
            psu_fan_on        <= psu;
            conv_tick         <= tick;
            card_temp_display <= disp_latched;
        end
    end

    assign s_axi_awready = !aw_hold;
    assign s_axi_wready  = !w_hold;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

endmodule : pidfan_top

// ---- test/pidfan_props.sv ----
`timescale 1ns/100ps
module pidfan_props #(
    parameter int CONV_CYCLES = 50
) (
    input wire logic                           mclk,
    input wire logic                           rst_n,
    input wire logic                           s_axi_awvalid,
    input wire logic                           s_axi_awready,
    input wire logic                           s_axi_wvalid,
    input wire logic                           s_axi_wready,
    input wire logic                           s_axi_bvalid,
    input wire logic                           s_axi_arvalid,
    input wire logic                           s_axi_arready,
    input wire logic                           s_axi_rvalid,
    input wire pidfan_pkg::pidfan_card_t [3:0] card_in,
    input wire logic [7:0]                     fan_speed,
    input wire logic [3:0]                     heater_enable,
    input wire logic [63:0]                    heater_drive,
    input wire logic                           conv_tick
);
    int cnt;
    int next_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last tick, zero before the first.
    always_comb next_cnt = conv_tick ? 1 : (cnt == 0 ? 0 : cnt + 1);
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            cnt <= 0;
        else
            cnt <= next_cnt;
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_tick_pulse: assert property (conv_tick |=> !conv_tick)
        else $error("tick too wide");
    chk_tick_period: assert property (conv_tick && cnt != 0 |-> cnt == CONV_CYCLES)
        else $error("tick spacing wrong");
    chk_fan_on_tick: assert property (!$stable(fan_speed) |-> $past(conv_tick))
        else $error("fan moved off tick");
    chk_drive_on_tick: assert property (!$stable(heater_drive)
        |-> $past(conv_tick) || $past(heater_enable) != 4'hF)
        else $error("drive moved off tick");
    chk_heater_trip: assert property (conv_tick && card_in[0].is_heater
        && card_in[0].card_temp > pidfan_pkg::HEATER_TRIP_TEMP |-> ##2 !heater_enable[0])
        else $error("hot heater left on");
    chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule : pidfan_props
bind pidfan_top pidfan_props #(.CONV_CYCLES(CONV_CYCLES)) i_pidfan_props (.*);

// ---- test/pidfan_cards.sv ----
`timescale 1ns/100ps
module pidfan_cards (
    input  wire logic                      mclk,
    input  wire logic                      conv_tick,
    input  wire logic                      hot,
    output pidfan_pkg::pidfan_card_t [3:0] card_in
);
    initial card_in = '0;
    // Two heater and two sensor cards; new readings after each sample.
    always @(posedge mclk)
        if (conv_tick)
        begin
            for (int i = 0; i < 4; i++)
                card_in[i] <= {i < 2, 16'(16'h0100 + $urandom % 16'h0200),
                               16'($urandom), 16'($urandom)};
            if (hot)
                card_in[0].card_temp <= 16'h0400;
        end
endmodule : pidfan_cards

// ---- test/tb_pid_loop_and_fan_arbiter.sv ----
`timescale 1ns/100ps
module tb_pid_loop_and_fan_arbiter;
    logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, standby, hot, psu_fan_on, conv_tick, card_temp_display, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, heater_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, fan_speed;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [63:0] heater_drive;
    logic [33:0] r;
    pidfan_pkg::pidfan_card_t [3:0] card_in;
    int errors, compares, kp, ki, kd, sp, integ, prev, d, ok, exd, exf, j;
    int ovr = -1;
    int thr = pidfan_pkg::COOL_THR_RESET;
    pidfan_top #(.CONV_CYCLES(50)) i_pidfan_top (.*);
    pidfan_cards i_pidfan_cards (.*);
    // Free-running 125 MHz clock.
    initial
    begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    task chk(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict();
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task bound(input logic c);
        chk(c, 1);
        if (!c)
            give_verdict();
    endtask : bound
    task tick();
        for (int i = 0; i < 200 && !conv_tick; i++)
            @(posedge mclk);
        bound(conv_tick);
        @(posedge mclk);
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (int i = 0; i < 50 && !(i > 0 && s_axi_bvalid); i++)
        begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 0;
            if (s_axi_wready)
                s_axi_wvalid <= 0;
        end
        bound(s_axi_bvalid);
    endtask : wr
    task rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (int i = 0; i < 50 && !(i > 0 && s_axi_rvalid); i++)
        begin
            @(posedge mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 0;
        end
        bound(s_axi_rvalid);
        r = {s_axi_rresp, s_axi_rdata};
    endtask : rdr
    function int drv(int t);
        int y;
        integ += ki * (sp - t);
        y = kp * (sp - t) + integ + kd * (prev - t);
        prev = t;
        return y > 32767 ? 32767 : (y < 0 ? 0 : y);
    endfunction : drv
    function int fan(pidfan_pkg::pidfan_card_t [3:0] c);
        int q, m;
        m = 0;
        for (int i = 0; i < 4; i++)
        begin
            if (c[i].is_heater)
                q = (c[i].card_temp > 400 ? c[i].card_temp - 400 : 0)
                    + c[i].load_current[15:10] + c[i].load_voltage[15:10];
            else
                q = c[i].card_temp < thr ? 0 : c[i].card_temp - thr + 16;
            m = q > m ? (q > 255 ? 255 : q) : m;
        end
        return m;
    endfunction : fan
    ////////////////////////////////////////////////////////////////////////
    // Expected values from each conversion's sample.
    always @(posedge mclk)
    begin
        if (d == 1 && ok)
        begin
            chk(heater_drive[15:0], exd[15:0]);
            chk(fan_speed, exf[7:0]);
        end
        if (d > 0)
            d--;
        if (conv_tick)
        begin
            exd = drv(card_in[0].card_temp);
            exf = ovr >= 0 ? ovr : fan(card_in);
            d = 2;
        end
    end
    // Main sequence.
    initial
    begin
        void'($urandom(32'h4837));
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, standby, hot, rst_n} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready} = 2'b11;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        rdr(pidfan_pkg::REG_COOL_THR);
        chk(r, 34'(pidfan_pkg::COOL_THR_RESET));
        rdr(pidfan_pkg::REG_LIMITS);
        chk(r, 34'(pidfan_pkg::LIMITS_RESET));
        rdr(8'h80);
        chk(r, 34'h2_0000_0000);
        tick();
        wr(pidfan_pkg::REG_CTRL, 1);
        wr(pidfan_pkg::REG_INT_EN, 1);
        for (j = 0; j < 8; j++)
        begin
            tick();
            kp = j == 7 ? 100 : $urandom % 16;
            ki = kp / 10;
            kd = $urandom % 8;
            sp = $urandom % 1024;
            thr = 16'h0100 + $urandom % 16'h0200;
            wr(pidfan_pkg::REG_GAIN_P, kp);
            wr(pidfan_pkg::REG_GAIN_I, ki);
            wr(pidfan_pkg::REG_GAIN_D, kd);
            wr(pidfan_pkg::REG_SETPT0, sp);
            wr(pidfan_pkg::REG_COOL_THR, thr);
            ok = 1;
        end
        chk(heater_enable[0], 1);
        rdr(pidfan_pkg::REG_STATUS);
        chk(r[0], 1);
        chk(irq, 1);
        wr(pidfan_pkg::REG_INT_EN, 0);
        repeat (2) @(posedge mclk);
        chk(irq, 0);
        wr(pidfan_pkg::REG_INT_EN, 1);
        tick();
        wr(pidfan_pkg::REG_INT_CLR, 1);
        repeat (2) @(posedge mclk);
        chk(irq, 0);
        tick();
        ovr = 90;
        wr(pidfan_pkg::REG_FAN_OVR, 32'h0000_015A);
        repeat (3) tick();
        wr(pidfan_pkg::REG_FAN_OVR, 0);
        ovr = -1;
        ok = 0;
        hot <= 1;
        repeat (2) tick();
        repeat (2) @(posedge mclk);
        chk(heater_enable[0], 0);
        rdr(pidfan_pkg::REG_OT_STAT);
        chk(r[0], 1);
        hot <= 0;
        repeat (2) tick();
        repeat (2) @(posedge mclk);
        chk(heater_enable[0], 0);
        wr(pidfan_pkg::REG_CTRL, 0);
        wr(pidfan_pkg::REG_CTRL, 3);
        chk(card_temp_display, 0);
        repeat (2) tick();
        repeat (2) @(posedge mclk);
        chk(heater_enable[0], 1);
        standby <= 1;
        for (j = 0; j < 5200 && psu_fan_on; j++)
            @(posedge mclk);
        for (j = 0; j < 5200 && !psu_fan_on; j++)
            @(posedge mclk);
        chk(psu_fan_on, 1);
        give_verdict();
    end
endmodule : tb_pid_loop_and_fan_arbiter
